// >>> design/lps_sampler.sv
/*
 * lps_sampler: digital input mode of the low-power sampler. Polls up to 64
 * inputs through an external 8-way mux, compares against reference values
 * and raises events on mismatch.
 * Assumes the interval timer triggers arrive as single-cycle pulses in the
 * clk domain, and inputs arrive asynchronously from pins.
 */
`timescale 1ns/1ps

// Summary of operation
// R01 - monitor up to 64 inputs by stepping the external mux select lines
// R02 - step the mux select lines exactly the programmed number of times
// R03 - start a sweep only on a pulse from the selected interval timer
// R04 - keep the fast oscillator requested for the whole sweep
// R05 - wait the programmed settling time after each new mux address
// R06 - store captures in monitor regs 0 to 7; references from three regs
// R07 - mismatch sets the event flag and asserts the wake request
// R08 - mismatch interrupt fires in run and in every standby mode
// R09 - raise sweep-done once all enabled inputs were checked
// R10 - drive the sensor control output and the mux select lines
// R11 - the feeding timer channel runs as a fixed-period interval timer
// R12 - sensor control output goes to 1 on first acquisition of a sweep
// R13 - settle delay is count times 16 periods of oscillator divided by 20
// R14 - select lines share pins with inputs 8 to 10; never use both
// R15 - after the last step return idle, release selects, await trigger
// R16 - only compare-enabled bits can cause a mismatch
module lps_sampler (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // timer triggers and configuration
    input  wire logic                   interval_timer_a,
    input  wire logic                   interval_timer_b,
    input  wire lps_pkg::lps_cfg_s      cfg,
    input  wire logic                   event_flag_clear,
    // pins
    input  wire logic [23:0]            digital_sense_input,
    output logic [2:0]                  mux_select_output,
    output logic                        mux_select_oe_n,
    output logic                        sensor_control_out,
    // status and events
    output logic                        fast_osc_request,
    output logic                        event_flag_reg,
    output lps_pkg::lps_evt_s           evt,
    output logic [63:0]                 input_monitor_regs
);

    lps_pkg::lps_state_e state_reg, state_next;
    logic [2:0]  step_reg;
    logic [7:0]  pre_reg;
    logic [4:0]  sub_reg;
    logic [7:0]  cnt_reg;
    logic [23:0] sync1_reg, sync2_reg, sync3_reg, stable_reg;

    // compare data for the current step; step 0 uses the low byte of the low field
    function automatic logic [7:0] ref_of(input lps_pkg::lps_cfg_s c, input logic [2:0] s);
        logic [7:0] r;
        r = 8'h00;
        case (s)
            3'd0:    r = c.ref_low[7:0];
            3'd1:    r = c.ref_mid[7:0];
            3'd2:    r = c.ref_mid[15:8];
            3'd3:    r = c.ref_mid[23:16];
            3'd4:    r = c.ref_mid[31:24];
            3'd5:    r = c.ref_high[7:0];
            3'd6:    r = c.ref_high[15:8];
            3'd7:    r = c.ref_high[23:16];
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // trigger selection and per-step compare
    wire        trig_pulse = cfg.trig_sel ? interval_timer_b : interval_timer_a;  // see R03
    wire [7:0]  cur_in     = stable_reg[7:0];
    wire [7:0]  cur_ref    = ref_of(cfg, step_reg);
    wire [7:0]  cur_en     = cfg.cmp_enable[{step_reg, 3'b000} +: 8];
    wire [7:0]  diff_bits  = (cur_in ^ cur_ref) & cur_en;                      // see R16
    wire        mismatch   = (state_reg == lps_pkg::LPS_SAMPLE) && (|diff_bits);
    wire        last_step  = (step_reg == cfg.step_count);                     // see R02
    wire        tick       = (pre_reg == 8'h00);
    wire        settle_end = tick && (sub_reg == 5'd1) && (cnt_reg <= 8'd1);   // see R13
    wire        zero_settle = (cfg.settle_count == 8'h00);

    // next values for the registered pins; selects drop as soon as the
    // sequencer heads for idle so the mux is never left on a stale address
    wire        going_idle = (state_next == lps_pkg::LPS_IDLE);
    wire        sampling   = (state_reg == lps_pkg::LPS_SAMPLE);
    wire        sweep_end  = sampling && last_step;
    wire [2:0]  step_inc   = step_reg + 3'h1;
    wire [2:0]  sel_next   = going_idle ? lps_pkg::SEL_RESET : (sampling ? step_inc : step_reg);

    // three-flop pin synchroniser; only stage two reads stage one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= digital_sense_input;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a bit is accepted once stages two and three agree, so a pin caught
    // mid-change is held back a cycle instead of captured half-settled
    for (genvar b = 0; b < 24; b++) begin : g_accept
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                stable_reg[b] <= 1'b0;
            end else if (sync2_reg[b] == sync3_reg[b]) begin
                stable_reg[b] <= sync3_reg[b];
            end
        end
    end

    // sequencer next state; limitation: a zero settle count samples before
    // the pins have crossed the synchroniser, so it still sees the old address
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            lps_pkg::LPS_IDLE:   if (trig_pulse) state_next = lps_pkg::LPS_WAKE;   // see R03
            lps_pkg::LPS_WAKE:   state_next = zero_settle ? lps_pkg::LPS_SAMPLE
                                                          : lps_pkg::LPS_SETTLE;
            lps_pkg::LPS_SETTLE: if (settle_end) state_next = lps_pkg::LPS_SAMPLE; // see R05
            lps_pkg::LPS_SAMPLE: state_next = last_step ? lps_pkg::LPS_IDLE         // see R15
                                                        : lps_pkg::LPS_NEXT;
            lps_pkg::LPS_NEXT:   state_next = zero_settle ? lps_pkg::LPS_SAMPLE
                                                          : lps_pkg::LPS_SETTLE;
            default:             state_next = lps_pkg::LPS_IDLE;
        endcase
    end

    // state and step counter; the step restarts at zero on every idle cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= lps_pkg::LPS_IDLE;
            step_reg  <= lps_pkg::SEL_RESET;
        end else begin
            state_reg <= state_next;
            if (state_reg == lps_pkg::LPS_IDLE) begin
                step_reg <= lps_pkg::SEL_RESET;
            end else if (sampling && !last_step) begin
                step_reg <= step_inc;                                           // see R02
            end
        end
    end

    // settle timer: pre makes the divided oscillator tick, sub counts sixteen
    // ticks, cnt counts programmed units; all reload whenever not settling
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_reg <= lps_pkg::TICK_LOAD;
            sub_reg <= lps_pkg::SETTLE_TICKS;
            cnt_reg <= 8'h00;
        end else if (state_reg == lps_pkg::LPS_SETTLE) begin
            pre_reg <= tick ? lps_pkg::TICK_LOAD : pre_reg - 8'h01;
            if (tick) begin
                sub_reg <= (sub_reg == 5'h01) ? lps_pkg::SETTLE_TICKS : sub_reg - 5'h01;
                if (sub_reg == 5'h01) cnt_reg <= cnt_reg - 8'h01;
            end
        end else begin
            pre_reg <= lps_pkg::TICK_LOAD;
            sub_reg <= lps_pkg::SETTLE_TICKS;
            cnt_reg <= cfg.settle_count;                                        // see R13
        end
    end

    // pins and oscillator request, all registered so the pads never glitch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mux_select_output <= lps_pkg::SEL_RESET;
            mux_select_oe_n   <= 1'b1;
            fast_osc_request  <= 1'b0;
        end else begin
            mux_select_output <= sel_next;                                      // see R01
            mux_select_oe_n   <= going_idle;                                    // see R10
            fast_osc_request  <= !going_idle;                                   // see R04
        end
    end

    // sensor control rises on the first capture and stays up one cycle past
    // the last step, so a single-step sweep still shows it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sensor_control_out <= 1'b0;
        end else if (state_reg == lps_pkg::LPS_IDLE) begin
            sensor_control_out <= 1'b0;
        end else if (sampling) begin
            sensor_control_out <= 1'b1;                                         // see R12
        end
    end

    // monitor bytes; steps beyond the count keep the previous capture
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            input_monitor_regs <= {lps_pkg::NUM_STEPS{lps_pkg::MON_RESET}};
        end else if (sampling) begin
            input_monitor_regs[{step_reg, 3'b000} +: 8] <= cur_in;              // see R06
        end
    end

    // sticky event flag; set wins over a clear in the same cycle so a
    // mismatch is never lost to a late software clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            event_flag_reg <= 1'b0;
        end else if (mismatch) begin
            event_flag_reg <= 1'b1;                                             // see R07
        end else if (event_flag_clear) begin
            event_flag_reg <= 1'b0;
        end
    end

    // one-cycle event pulses; nothing here looks at the standby state, so
    // the mismatch pulse fires in run and standby alike
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt <= '0;
        end else begin
            evt.mismatch_irq     <= mismatch;                                   // see R08
            evt.wake_request_out <= mismatch;                                   // see R07
            evt.sweep_done_irq   <= sweep_end;                                  // see R09
        end
    end

endmodule

// >>> shared/lps_pkg.sv
/*
 * lps_pkg: constants and carrier types for the digital input poll sampler.
 * Assumes a single 100 MHz clock domain; the fast oscillator rate is set here.
 */
package lps_pkg;

    // geometry
    localparam int unsigned NUM_STEPS   = 8;    // mux steps, monitor regs 0 to 7
    localparam int unsigned IN_WIDTH    = 8;    // inputs sampled per mux step
    localparam int unsigned SEL_WIDTH   = 3;    // mux select lines
    localparam int unsigned REF0_WIDTH  = 24;   // unused upper bits in low ref set
    localparam int unsigned MAX_INPUTS  = 64;   // inputs reachable through the mux

    // settling: cnt * 16 periods of (osc / 20)
    localparam int unsigned OSC_DIV         = 20;
    localparam int unsigned SETTLE_MULT     = 16;
    localparam int unsigned CLK_PER_OSC_DIV = 2;    // clk cycles per divided osc tick
    localparam int unsigned TICK_PRESCALE   = CLK_PER_OSC_DIV;  // clk cycles per settle tick
    localparam logic [7:0]  TICK_LOAD       = 8'(TICK_PRESCALE - 1);
    localparam logic [4:0]  SETTLE_TICKS    = 5'(SETTLE_MULT);

    // reset values
    localparam logic [2:0]  SEL_RESET   = 3'h0;
    localparam logic [7:0]  MON_RESET   = 8'h00;

    // sampler states
    typedef enum logic [2:0] {
        LPS_IDLE   = 3'b000,
        LPS_WAKE   = 3'b001,
        LPS_SETTLE = 3'b010,
        LPS_SAMPLE = 3'b011,
        LPS_NEXT   = 3'b100
    } lps_state_e;

    // software configuration bundle
    typedef struct packed {
        logic [2:0]  step_count;     // steps per sweep minus one
        logic [7:0]  settle_count;   // settle_count_field
        logic        trig_sel;       // 0: interval_timer_a, 1: interval_timer_b
        logic [31:0] ref_low;        // reference_set_low_reg
        logic [31:0] ref_mid;        // reference_set_mid_reg
        logic [31:0] ref_high;       // reference_set_high_reg
        logic [63:0] cmp_enable;     // per-bit compare enable, 8 per step
    } lps_cfg_s;

    // event outputs
    typedef struct packed {
        logic mismatch_irq;
        logic sweep_done_irq;
        logic wake_request_out;
    } lps_evt_s;

endpackage

// >>> bench/lps_sampler_properties.sv
/* lps_sampler_chk: port assertions for the poll sampler.
   assumes bind onto lps_sampler and cfg held still during a sweep. */
`timescale 1ns/1ps
module lps_sampler_chk (
    // clock, reset, triggers, config
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              interval_timer_a,
    input wire logic              interval_timer_b,
    input wire lps_pkg::lps_cfg_s cfg,
    // outputs watched
    input wire logic [2:0]        mux_select_output,
    input wire logic              mux_select_oe_n,
    input wire logic              sensor_control_out,
    input wire logic              fast_osc_request,
    input wire logic              event_flag_reg,
    input wire lps_pkg::lps_evt_s evt
);
    // the trigger the sampler should listen to
    wire logic trig;
    assign trig = cfg.trig_sel ? interval_timer_b : interval_timer_a;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_sweep_start: assert property (!fast_osc_request && trig |=> fast_osc_request)
        else $error("sweep did not start on trigger");
    a_no_stray: assert property (!fast_osc_request && !trig |=> !fast_osc_request)
        else $error("sweep started without trigger");
    a_oe_tracks: assert property (mux_select_oe_n == !fast_osc_request)
        else $error("select enable out of step");
    a_idle_sel: assert property (!fast_osc_request |-> mux_select_output == 3'h0)
        else $error("select not released");
    a_step_limit: assert property (mux_select_output <= cfg.step_count)
        else $error("select beyond step count");
    a_settle_wait: assert property (fast_osc_request && cfg.settle_count != 8'h00
        && $changed(mux_select_output) |=> $stable(mux_select_output)[*8])
        else $error("select moved before settling");
    a_done_pulse: assert property (evt.sweep_done_irq |-> !fast_osc_request ##1 !evt.sweep_done_irq)
        else $error("sweep done pulse wrong");
    a_wake_pair: assert property (evt.mismatch_irq == evt.wake_request_out)
        else $error("wake and mismatch differ");
    a_flag_set: assert property (evt.mismatch_irq |-> ##[0:1] event_flag_reg)
        else $error("event flag not set");
    a_ctl_sweep: assert property (sensor_control_out |-> fast_osc_request || evt.sweep_done_irq)
        else $error("sensor control outside sweep");
endmodule
bind lps_sampler lps_sampler_chk lps_sampler_chk_i (.clk(clk), .rstn(rstn),
    .interval_timer_a(interval_timer_a), .interval_timer_b(interval_timer_b), .cfg(cfg),
    .mux_select_output(mux_select_output), .mux_select_oe_n(mux_select_oe_n),
    .sensor_control_out(sensor_control_out), .fast_osc_request(fast_osc_request),
    .event_flag_reg(event_flag_reg), .evt(evt));

// >>> bench/lps_mux_model.sv
/* lps_mux_model: external 8-way mux in front of the sense pins.
   assumes select lines valid only while their enable is low. */
`timescale 1ns/1ps
module lps_mux_model (
    // select side
    input  wire logic [2:0]  sel,
    input  wire logic        sel_oe_n,
    // sources, one byte per step
    input  wire logic [63:0] src,
    output logic [23:0]      sense
);
    // released select shows inverted data, so a stale capture cannot pass
    // upper pins kept quiet: they double as select lines
    assign sense = sel_oe_n ? {16'h0000, ~src[7:0]} : {16'h0000, src[8*sel +: 8]};
endmodule

// >>> bench/test_lps_sampler.sv
/* test_lps_sampler: self-checking bench for the poll sampler.
   assumes lps_mux_model as far side and one 100 MHz clock. */
`timescale 1ns/1ps
module test_lps_sampler;
    logic clk, rstn, tim_a, tim_b, clr, oe_n, ctl, osc, flag;
    lps_pkg::lps_cfg_s cfg;
    lps_pkg::lps_evt_s evt;
    logic [63:0] src, mon;
    logic [23:0] sense;
    logic [2:0]  sel;
    int miscompares = 0, checks = 0, n_mm = 0, n_wake = 0, n_done = 0, n_ctl = 0, cyc;
    lps_sampler lps_sampler_i (.clk(clk), .rstn(rstn), .interval_timer_a(tim_a),
        .interval_timer_b(tim_b), .cfg(cfg), .event_flag_clear(clr), .digital_sense_input(sense),
        .mux_select_output(sel), .mux_select_oe_n(oe_n), .sensor_control_out(ctl),
        .fast_osc_request(osc), .event_flag_reg(flag), .evt(evt), .input_monitor_regs(mon));
    lps_mux_model lps_mux_model_i (.sel(sel), .sel_oe_n(oe_n), .src(src), .sense(sense));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // event pulses counted as they stand
    always @(posedge clk) begin
        if (evt.mismatch_irq === 1'b1) n_mm++;
        if (evt.wake_request_out === 1'b1) n_wake++;
        if (evt.sweep_done_irq === 1'b1) n_done++;
        if (ctl === 1'b1) n_ctl++;
    end
    task check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task set_ref(input logic [63:0] d, input logic [63:0] en);
        cfg.ref_low = {24'h00_0000, d[7:0]};
        cfg.ref_mid = d[39:8];
        cfg.ref_high = {8'h00, d[63:40]};
        cfg.cmp_enable = en;
    endtask
    // one trigger, a second one mid-run that must be ignored, bounded wait
    task sweep(input logic use_b);
        n_mm = 0;
        n_wake = 0;
        n_done = 0;
        n_ctl = 0;
        tim_a = !use_b;
        tim_b = use_b;
        for (cyc = 0; cyc < 2000; cyc++) begin
            @(negedge clk);
            tim_b = 1'b0;
            tim_a = 1'(cyc == 40);
            if (osc !== 1'b1) break;
        end
        if (cyc == 2000) begin
            miscompares++;
            end_of_test;
        end
        repeat (2) @(negedge clk);
    endtask
    task t_match;
        src = 64'h8877_6655_4433_2211;
        set_ref(src, '1);
        sweep(1'b1);
        check(64'(n_done), 64'h0000_0000_0000_0000);
        sweep(1'b0);
        check(64'(n_done), 64'h0000_0000_0000_0001);
        check(64'(cyc >= 256 && cyc <= 320), 64'h0000_0000_0000_0001);
        check(64'(n_mm), 64'h0000_0000_0000_0000);
        check(mon, src);
        check(64'(n_ctl != 0), 64'h0000_0000_0000_0001);
        $display("t_match finished, miscompares %0d", miscompares);
    endtask
    // byte 3 bit 0 differs: masked it stays quiet, enabled it wakes
    task t_mismatch;
        cfg.trig_sel = 1'b1;
        set_ref(src ^ 64'h0000_0000_0100_0000, ~64'h0000_0000_0100_0000);
        sweep(1'b1);
        check(64'(n_mm), 64'h0000_0000_0000_0000);
        cfg.cmp_enable = '1;
        sweep(1'b1);
        check(64'(n_mm), 64'h0000_0000_0000_0001);
        check(64'(n_wake), 64'h0000_0000_0000_0001);
        check(64'(flag), 64'h0000_0000_0000_0001);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        @(negedge clk);
        check(64'(flag), 64'h0000_0000_0000_0000);
        $display("t_mismatch finished, miscompares %0d", miscompares);
    endtask
    // three steps: upper monitors keep the last sweep's bytes
    task t_short;
        cfg.step_count = 3'h2;
        src = 64'h1122_3344_5566_7788;
        set_ref(src, '1);
        sweep(1'b1);
        check(64'({n_done, n_mm}), 64'h0000_0001_0000_0000);
        check(mon, 64'h8877_6655_4466_7788);
        $display("t_short finished, miscompares %0d", miscompares);
    endtask
    initial begin
        rstn = 1'b0;
        {tim_a, tim_b, clr} = 3'h0;
        cfg = '0;
        src = '0;
        cfg.step_count = 3'h7;
        cfg.settle_count = 8'h01;
        repeat (10) @(negedge clk);
        check(64'({oe_n, osc, sel, flag, ctl}), 64'h0000_0000_0000_0040);
        check(mon, 64'h0000_0000_0000_0000);
        check(64'(evt), 64'h0000_0000_0000_0000);
        $display("reset check finished, miscompares %0d", miscompares);
        rstn = 1'b1;
        t_match;
        t_mismatch;
        t_short;
        end_of_test;
    end
endmodule
